// [core/opp_ctrl.sv]
/*
  Optimized 1+1 protection switching controller for two SDH line ports.
  Holds the guard and reversion timers, the Force handshake over K1 and
  the Avalon-MM register port. Line failure and far-end K1 inputs come
  from the line framers on other clocks and are synchronised here.
*/
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// How it works
// - Revertive mode uses a reversion interval of 0.5 to 12 min, default 5 min.
// - Reversion timer runs only once the switch-causing failure has cleared.
// - Reversion expiry swaps primary and secondary roles.
// - Verification guard interval selectable from 500 ms to 1 s.
// - Accepted Force sets transmitted K1 to Force and starts verification timer.
// - No far-end acknowledgement before expiry withdraws and clears the Force.
// - Recovery guard interval selectable 0 to 10 s, default 1 s.
// - Cleared SD/SF is declared clear only after the recovery interval.
// - Detection guard interval selectable 0 to 5 s, default 1 s.
// - Active port failure switches to standby only after detection interval.
// - Only ports framed as SDH may join the group.
module opp_ctrl (
  input  wire logic        sys_clk_i,          // 200 MHz clock
  input  wire logic        arst_n_i,           // Async reset, active low
  input  wire logic [3:0]  avs_address,        // Word address
  input  wire logic        avs_read,           // Read strobe
  input  wire logic        avs_write,          // Write strobe
  input  wire logic [31:0] avs_writedata,      // Write data
  input  wire logic [3:0]  avs_byteenable,     // Byte enables
  output logic [31:0]      avs_readdata,       // Read data
  output logic             avs_waitrequest,    // Wait request
  input  wire logic        line_a_fail_i,      // SD/SF/LOS/LOF/AIS-L on port A
  input  wire logic        line_b_fail_i,      // SD/SF/LOS/LOF/AIS-L on port B
  input  wire logic        far_force_ack_i,    // Far end acknowledges Force
  output logic [7:0]       k1_tx_o,            // Transmitted K1 byte
  output logic             sel_b_o             // Traffic taken from port B
);
  localparam int CW = 20;

  typedef enum logic [1:0] {
    F_IDLE   = 2'b00,
    F_VERIFY = 2'b01,
    F_HELD   = 2'b10
  } force_type;

  typedef struct packed {
    logic [17:0]  tick_cnt;
    logic         tick;
    logic [1:0]   sync_a;
    logic [1:0]   sync_b;
    logic [1:0]   sync_ack;
    logic [5:0]   ctrl;
    logic [CW-1:0] rev_ms;
    logic [CW-1:0] ver_ms;
    logic [CW-1:0] rec_ms;
    logic [CW-1:0] det_ms;
    logic         active_b;
    logic         primary_b;
    logic         switched;
    logic [CW-1:0] rev_cnt;
    force_type    fstate;
    logic [CW-1:0] ver_cnt;
    logic         force_drop;
    logic         ack;
    logic [31:0]  rdata;
    logic [7:0]   k1;
  } state_type;

  state_type st;
  state_type next_st;
  logic      fail_a;
  logic      fail_b;

  opp_line_guard #(.CW(CW)) u_guard_a (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .tick_i    (st.tick),
    .fail_i    (st.sync_a[1]),
    .det_ms_i  (st.det_ms),
    .rec_ms_i  (st.rec_ms),
    .failed_o  (fail_a)
  );

  opp_line_guard #(.CW(CW)) u_guard_b (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .tick_i    (st.tick),
    .fail_i    (st.sync_b[1]),
    .det_ms_i  (st.det_ms),
    .rec_ms_i  (st.rec_ms),
    .failed_o  (fail_b)
  );

  function automatic logic [CW-1:0] clip(input logic [31:0] v, input int unsigned lo, input int unsigned hi);
    logic [31:0] r;
    r = v;
    if (r < lo) r = lo;
    if (r > hi) r = hi;
    return r[CW-1:0];
  endfunction : clip

  always_comb begin
    logic eligible;
    logic act_fail;
    logic stby_fail;
    logic wr;
    logic rd;
    eligible  = 1'b0;
    act_fail  = 1'b0;
    stby_fail = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    next_st   = st;

    next_st.sync_a   = {st.sync_a[0], line_a_fail_i};
    next_st.sync_b   = {st.sync_b[0], line_b_fail_i};
    next_st.sync_ack = {st.sync_ack[0], far_force_ack_i};

    // Common 1 ms tick shared by every timer
    next_st.tick = 1'b0;
    if (st.tick_cnt == 18'(opp_pkg::TICK_CYCLES - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick     = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 18'h1;
    end

    eligible = st.ctrl[opp_pkg::CTRL_ENABLE] && st.ctrl[opp_pkg::CTRL_SDH_A]
               && st.ctrl[opp_pkg::CTRL_SDH_B];
    act_fail  = st.active_b ? fail_b : fail_a;
    stby_fail = st.active_b ? fail_a : fail_b;

    wr = avs_write && !avs_read;
    rd = avs_read && !avs_write;

    // Register writes; intervals are clamped into their legal ranges
    if (wr && avs_byteenable[0]) begin
      unique case (avs_address)
        opp_pkg::CTRL_OFS: next_st.ctrl   = avs_writedata[5:0];
        opp_pkg::REV_OFS:  next_st.rev_ms = clip(avs_writedata, opp_pkg::REV_MIN_MS, opp_pkg::REV_MAX_MS);
        opp_pkg::VER_OFS:  next_st.ver_ms = clip(avs_writedata, opp_pkg::VER_MIN_MS, opp_pkg::VER_MAX_MS);
        opp_pkg::REC_OFS:  next_st.rec_ms = clip(avs_writedata, 0, opp_pkg::REC_MAX_MS);
        opp_pkg::DET_OFS:  next_st.det_ms = clip(avs_writedata, 0, opp_pkg::DET_MAX_MS);
        default: ;
      endcase
    end

    // Sticky Force-dropped flag: write 1 to clear, a new drop wins
    if (wr && avs_address == opp_pkg::STAT_OFS && avs_byteenable[0]
        && avs_writedata[opp_pkg::STAT_FORCE_DROP]) begin
      next_st.force_drop = 1'b0;
    end

    next_st.ack = st.sync_ack[1];

    // Force handshake with the far end
    unique case (st.fstate)
      F_IDLE: begin
        next_st.k1 = opp_pkg::K1_IDLE;
        if (eligible && st.ctrl[opp_pkg::CTRL_FORCE]
            && (!st.ctrl[opp_pkg::CTRL_LOCKOUT] || !stby_fail)) begin
          next_st.fstate  = F_VERIFY;
          next_st.k1      = opp_pkg::K1_FORCE;
          next_st.ver_cnt = '0;
        end
      end
      F_VERIFY: begin
        if (st.ack) begin
          next_st.fstate   = F_HELD;
          next_st.active_b = !st.active_b;
          next_st.switched = 1'b0;
        end else if (st.ver_cnt >= st.ver_ms) begin
          next_st.fstate     = F_IDLE;
          next_st.k1         = opp_pkg::K1_IDLE;
          next_st.ctrl[opp_pkg::CTRL_FORCE] = 1'b0;
          next_st.force_drop = 1'b1;
        end else if (st.tick) begin
          next_st.ver_cnt = st.ver_cnt + 1'b1;
        end
      end
      F_HELD: begin
        if (!st.ctrl[opp_pkg::CTRL_FORCE] || !eligible) begin
          next_st.fstate = F_IDLE;
          next_st.k1     = opp_pkg::K1_IDLE;
        end
      end
      default: next_st.fstate = F_IDLE;
    endcase

    // Automatic switching; failures already qualified by the guards
    if (eligible && st.fstate != F_HELD && act_fail && !stby_fail
        && !st.ctrl[opp_pkg::CTRL_LOCKOUT]) begin
      next_st.active_b = !st.active_b;
      next_st.switched = 1'b1;
      next_st.rev_cnt  = '0;
    end else if (st.switched && st.ctrl[opp_pkg::CTRL_REVERTIVE]) begin
      if (fail_a || fail_b) begin
        next_st.rev_cnt = '0;
      end else if (st.rev_cnt >= st.rev_ms) begin
        next_st.primary_b = st.active_b;
        next_st.switched  = 1'b0;
        next_st.rev_cnt   = '0;
      end else if (st.tick) begin
        next_st.rev_cnt = st.rev_cnt + 1'b1;
      end
    end

    if (rd) begin
      unique case (avs_address)
        opp_pkg::CTRL_OFS: next_st.rdata = {26'h0, st.ctrl};
        opp_pkg::REV_OFS:  next_st.rdata = 32'(st.rev_ms);
        opp_pkg::VER_OFS:  next_st.rdata = 32'(st.ver_ms);
        opp_pkg::REC_OFS:  next_st.rdata = 32'(st.rec_ms);
        opp_pkg::DET_OFS:  next_st.rdata = 32'(st.det_ms);
        opp_pkg::STAT_OFS: next_st.rdata = {24'h0, st.switched, eligible, fail_b, fail_a,
                                            st.force_drop, st.fstate == F_HELD,
                                            st.primary_b, st.active_b};
        default:           next_st.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st        <= '0;
      st.ctrl   <= opp_pkg::CTRL_RESET;
      st.rev_ms <= CW'(opp_pkg::REV_DEF_MS);
      st.ver_ms <= CW'(opp_pkg::VER_DEF_MS);
      st.rec_ms <= CW'(opp_pkg::REC_DEF_MS);
      st.det_ms <= CW'(opp_pkg::DET_DEF_MS);
      st.fstate <= F_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Zero-wait writes; reads answer one cycle later from registered data
  logic rd_done;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_done <= 1'b0;
    end else begin
      rd_done <= avs_read && !rd_done;
    end
  end

  assign avs_waitrequest = avs_read && !rd_done;
  assign avs_readdata    = st.rdata;
  assign k1_tx_o         = st.k1;
  assign sel_b_o         = st.active_b;
endmodule : opp_ctrl

// [core/opp_pkg.sv]
/*
  Shared constants for the optimized 1+1 protection switching controller:
  register offsets, field positions, reset values and timing counts.
  Assumes a 200 MHz system clock and a 32-bit Avalon-MM register port.
*/
package opp_pkg;
  // Timer tick: 1 ms base, fine enough for 0.5 min, 500 ms and 0 s steps
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;

  // Interval limits and defaults, in ms
  localparam int unsigned REV_MIN_MS      = 30_000;
  localparam int unsigned REV_MAX_MS      = 720_000;
  localparam int unsigned REV_DEF_MS      = 300_000;
  localparam int unsigned VER_MIN_MS      = 500;
  localparam int unsigned VER_MAX_MS      = 1000;
  localparam int unsigned VER_DEF_MS      = 500;
  localparam int unsigned REC_MAX_MS      = 10_000;
  localparam int unsigned REC_DEF_MS      = 1000;
  localparam int unsigned DET_MAX_MS      = 5000;
  localparam int unsigned DET_DEF_MS      = 1000;

  // Register word offsets
  localparam logic [3:0] CTRL_OFS         = 4'h0;
  localparam logic [3:0] REV_OFS          = 4'h1;
  localparam logic [3:0] VER_OFS          = 4'h2;
  localparam logic [3:0] REC_OFS          = 4'h3;
  localparam logic [3:0] DET_OFS          = 4'h4;
  localparam logic [3:0] STAT_OFS         = 4'h5;

  // Control register fields
  localparam int unsigned CTRL_REVERTIVE  = 0;
  localparam int unsigned CTRL_LOCKOUT    = 1;
  localparam int unsigned CTRL_FORCE      = 2;
  localparam int unsigned CTRL_SDH_A      = 3;
  localparam int unsigned CTRL_SDH_B      = 4;
  localparam int unsigned CTRL_ENABLE     = 5;
  localparam logic [5:0] CTRL_RESET       = 6'h39;

  // Status register fields
  localparam int unsigned STAT_ACTIVE_B   = 0;
  localparam int unsigned STAT_PRIMARY_B  = 1;
  localparam int unsigned STAT_FORCE_ON   = 2;
  localparam int unsigned STAT_FORCE_DROP = 3;
  localparam int unsigned STAT_FAIL_A     = 4;
  localparam int unsigned STAT_FAIL_B     = 5;
  localparam int unsigned STAT_ELIGIBLE   = 6;
  localparam int unsigned STAT_REV_RUN    = 7;

  // K1 request codes: idle, and the code sent while a Force is being signalled
  localparam logic [7:0] K1_IDLE          = 8'h00;
  localparam logic [7:0] K1_FORCE         = 8'he1;
endpackage : opp_pkg

// [core/opp_line_guard.sv]
/*
  Per-line failure qualifier: raw failure must persist for the detection
  interval before it is declared, and a cleared SD/SF must stay clear for
  the recovery interval before the declaration drops.
  Assumes failure inputs already synchronised and a one-cycle ms tick.
*/
`timescale 1ns/1ps
module opp_line_guard #(
  parameter int unsigned CW = 20
) (
  input  wire logic          sys_clk_i,   // System clock
  input  wire logic          arst_n_i,    // Async reset, active low
  input  wire logic          tick_i,      // 1 ms tick pulse
  input  wire logic          fail_i,      // Raw line failure level
  input  wire logic [CW-1:0] det_ms_i,    // Detection interval
  input  wire logic [CW-1:0] rec_ms_i,    // Recovery interval
  output logic               failed_o     // Qualified failure
);
  typedef struct packed {
    logic          failed;
    logic [CW-1:0] cnt;
  } state_type;

  state_type st;
  state_type next_st;

  always_comb begin
    next_st = st;
    if (fail_i == st.failed) begin
      next_st.cnt = '0;
    end else if ((fail_i ? det_ms_i : rec_ms_i) <= st.cnt) begin
      next_st.failed = fail_i;
      next_st.cnt    = '0;
    end else if (tick_i) begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign failed_o = st.failed;
endmodule : opp_line_guard

// [tb/opp_far_end.sv]
/* Far-end node model: acknowledges a transmitted Force after a set delay.
   Assumes the near end's clock and a bench that sets delay and willingness. */
`timescale 1ns/1ps
module opp_far_end (
  input  wire logic       sys_clk_i, // Clock
  input  wire logic       arst_n_i,  // Reset, low
  input  wire logic [7:0] k1_rx_i,   // Received K1
  input  wire logic       ack_en_i,  // Willing to ack
  input  wire logic [7:0] delay_i,   // Ack delay, cycles
  output logic            ack_o      // Force acknowledged
);
  logic [7:0] cnt;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt   <= 8'h00;
      ack_o <= 1'b0;
    end else if (k1_rx_i == opp_pkg::K1_FORCE && ack_en_i) begin
      cnt   <= (cnt == delay_i) ? cnt : cnt + 8'h01;
      ack_o <= (cnt == delay_i);
    end else begin
      cnt   <= 8'h00;
      ack_o <= 1'b0;
    end
  end
endmodule : opp_far_end

// [tb/opp_ctrl_assertions.sv]
/* Port checker for the protection controller.
   Bound to every controller instance; sees its ports only. */
`timescale 1ns/1ps
module opp_ctrl_assertions (
  input wire logic        sys_clk_i,       // Clock
  input wire logic        arst_n_i,        // Reset, low
  input wire logic [3:0]  avs_address,     // Address
  input wire logic        avs_read,        // Read
  input wire logic        avs_write,       // Write
  input wire logic [31:0] avs_writedata,   // Write data
  input wire logic [3:0]  avs_byteenable,  // Byte enables
  input wire logic [31:0] avs_readdata,    // Read data
  input wire logic        avs_waitrequest, // Wait
  input wire logic        line_a_fail_i,   // Port A failure
  input wire logic        line_b_fail_i,   // Port B failure
  input wire logic        far_force_ack_i, // Far-end ack
  input wire logic [7:0]  k1_tx_o,         // K1 out
  input wire logic        sel_b_o          // Port B selected
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [3:0] quiet;
  logic       ctrl_wr;
  assign ctrl_wr = avs_write && avs_byteenable[0] && avs_address == opp_pkg::CTRL_OFS && avs_writedata[2];
  // Cycles since any failure or acknowledge was last seen
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) quiet <= 4'h0;
    else if (line_a_fail_i || line_b_fail_i || far_force_ack_i) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  sequence s_read_answer; avs_waitrequest ##1 !avs_waitrequest; endsequence
  sequence s_force_up; ##2 k1_tx_o == opp_pkg::K1_FORCE; endsequence
  property p_read_wait; $rose(avs_read) |-> s_read_answer; endproperty
  property p_write_nowait; avs_write |-> !avs_waitrequest; endproperty
  property p_rd_hold; !avs_read && $past(!avs_read) |-> $stable(avs_readdata); endproperty
  property p_k1_legal; k1_tx_o == opp_pkg::K1_IDLE || k1_tx_o == opp_pkg::K1_FORCE; endproperty
  property p_force_start; ctrl_wr && avs_writedata[5:1] == 5'h1e |-> s_force_up; endproperty
  property p_force_hold; $rose(k1_tx_o == opp_pkg::K1_FORCE) |-> (k1_tx_o == opp_pkg::K1_FORCE)[*8]; endproperty
  property p_sdh_only;
    ctrl_wr && avs_writedata[4:3] != 2'h3 && k1_tx_o == opp_pkg::K1_IDLE |=> (k1_tx_o == opp_pkg::K1_IDLE)[*4];
  endproperty
  property p_switch_cause; $changed(sel_b_o) |-> quiet < 4'ha; endproperty
  a_read_wait: assert property (p_read_wait) else $error("read answer timing wrong");
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside a read");
  a_k1_legal: assert property (p_k1_legal) else $error("unknown K1 code sent");
  a_force_start: assert property (p_force_start) else $error("Force not signalled on K1");
  a_force_hold: assert property (p_force_hold) else $error("Force withdrawn too early");
  a_sdh_only: assert property (p_sdh_only) else $error("Force sent from non-SDH group");
  a_switch_cause: assert property (p_switch_cause) else $error("switch without cause");
endmodule : opp_ctrl_assertions
bind opp_ctrl opp_ctrl_assertions chk_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_a_fail_i(line_a_fail_i),
  .line_b_fail_i(line_b_fail_i), .far_force_ack_i(far_force_ack_i), .k1_tx_o(k1_tx_o), .sel_b_o(sel_b_o));

// [tb/optimized_one_plus_one_protection_tb_top.sv]
/* Bench for the protection controller: register defaults and limits, guards, Force handshake.
   Assumes the far-end model and the bound port checker. */
`timescale 1ns/1ps
module optimized_one_plus_one_protection_tb_top;
  logic        sys_clk_i, arst_n_i, avs_read, avs_write, line_a_fail_i, line_b_fail_i;
  logic        far_force_ack_i, sel_b_o, avs_waitrequest, ack_en;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  k1_tx_o, ack_dly;
  int          miscompares, checks_done, cycles;
  opp_ctrl dut_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_a_fail_i(line_a_fail_i),
    .line_b_fail_i(line_b_fail_i), .far_force_ack_i(far_force_ack_i), .k1_tx_o(k1_tx_o), .sel_b_o(sel_b_o));
  opp_far_end far_u (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .k1_rx_i(k1_tx_o), .ack_en_i(ack_en),
    .delay_i(ack_dly), .ack_o(far_force_ack_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end
  task summarize;
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task do_reset;
    arst_n_i      <= 1'b0;
    line_a_fail_i <= 1'b0;
    line_b_fail_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    @(posedge sys_clk_i);
  endtask : do_reset
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge sys_clk_i); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task wait_sel(input logic e, input int m);
    for (int n = 0; n < m && sel_b_o !== e; n++) @(posedge sys_clk_i);
    chk({31'h0, sel_b_o}, {31'h0, e});
  endtask : wait_sel
  task wait_k1(input int n, input logic [7:0] e);
    repeat (n) @(posedge sys_clk_i);
    chk({24'h0, k1_tx_o}, {24'h0, e});
  endtask : wait_k1
  task t_regs;
    logic [31:0] dflt [6] = '{32'h39, 300000, 500, 1000, 1000, 32'h40};
    logic [31:0] cw [5] = '{0, 2000, 20000, 9999, 0};
    logic [31:0] ce [5] = '{30000, 1000, 10000, 5000, 500};
    logic [3:0]  ca [5] = '{1, 2, 3, 4, 2};
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 4'(i), 32'h0);
      chk(rd, dflt[i]);
    end
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ca[i], cw[i]);
      bus(1'b0, ca[i], 32'h0);
      chk(rd, ce[i]);
    end
    avs_byteenable <= 4'he;
    bus(1'b1, opp_pkg::DET_OFS, 32'h7);
    avs_byteenable <= 4'hf;
    bus(1'b0, opp_pkg::DET_OFS, 32'h0);
    chk(rd, 32'd5000);
    bus(1'b1, 4'hf, 32'hffff);
    bus(1'b0, 4'hf, 32'h0);
    chk(rd, 32'h0);
  endtask : t_regs
  task t_guard;
    do_reset();
    line_a_fail_i <= 1'b1;
    repeat (200) @(posedge sys_clk_i);
    chk({31'h0, sel_b_o}, 32'h0);
    for (int r = 0; r < 2; r++) begin
      do_reset();
      bus(1'b1, opp_pkg::DET_OFS, 32'h0);
      bus(1'b1, opp_pkg::REC_OFS, r ? 32'h0 : 32'd1000);
      line_a_fail_i <= 1'b1;
      wait_sel(1'b1, 20);
      line_a_fail_i <= 1'b0;
      repeat (30) @(posedge sys_clk_i);
      bus(1'b0, opp_pkg::STAT_OFS, 32'h0);
      chk({31'h0, rd[opp_pkg::STAT_FAIL_A]}, r ? 32'h0 : 32'h1);
    end
  endtask : t_guard
  task t_force;
    for (int d = 1; d < 60; d += 50) begin
      do_reset();
      ack_dly <= 8'(d);
      bus(1'b1, opp_pkg::CTRL_OFS, 32'h3c);
      wait_k1(2, opp_pkg::K1_FORCE);
      wait_sel(1'b1, 100);
      bus(1'b0, opp_pkg::STAT_OFS, 32'h0);
      chk({31'h0, rd[opp_pkg::STAT_FORCE_ON]}, 32'h1);
    end
    do_reset();
    ack_en <= 1'b0;
    bus(1'b1, opp_pkg::CTRL_OFS, 32'h3c);
    wait_k1(300, opp_pkg::K1_FORCE);
    do_reset();
    ack_en <= 1'b1;
    bus(1'b1, opp_pkg::DET_OFS, 32'h0);
    line_b_fail_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    bus(1'b1, opp_pkg::CTRL_OFS, 32'h3e);
    wait_k1(20, opp_pkg::K1_IDLE);
    do_reset();
    bus(1'b1, opp_pkg::CTRL_OFS, 32'h2c);
    wait_k1(20, opp_pkg::K1_IDLE);
    bus(1'b0, opp_pkg::STAT_OFS, 32'h0);
    chk({31'h0, rd[opp_pkg::STAT_ELIGIBLE]}, 32'h0);
  endtask : t_force
  initial begin
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_address    = 4'h0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
    ack_en         = 1'b1;
    ack_dly        = 8'h01;
    do_reset();
    t_regs();
    t_guard();
    t_force();
    summarize();
  end
endmodule : optimized_one_plus_one_protection_tb_top
